// file: rtl/event_counter.sv
/*
  One 16-bit wrapping event counter with a synchronous clear.
  Assumes: inc and clr come from logic on the same clock.
*/
`timescale 1ns/1ps
module event_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [WIDTH-1:0] count_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } state_type;
  state_type st_reg;
  state_type st_next;

  always_comb begin
    st_next = st_reg;
    // clear wins: a clear request resets the count outright
    if (clr_i) begin
      st_next.cnt = '0;
    end else if (inc_i) begin
      st_next.cnt = st_reg.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_o = st_reg.cnt;

  chk_wrap_to_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (inc_i && !clr_i && st_reg.cnt == '1) |=> st_reg.cnt == '0)
    else $error("counter did not wrap to zero");
endmodule

// file: rtl/holding_regs.sv
/*
  Small register memory for the holding registers, one write port,
  one read port with registered read data. Unused bits of the port
  word are masked on write by the caller.
  Assumes: addresses already range-checked by the caller.
*/
`timescale 1ns/1ps
module holding_regs #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [15:0] rd_data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0] rdata;
  } state_type;
  state_type st_reg;
  state_type st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en_i) begin
      st_next.mem[wr_addr_i] = wr_data_i;
    end
    st_next.rdata = st_reg.mem[rd_addr_i];
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_o = st_reg.rdata;
endmodule

// file: rtl/mb_srv_handler.sv
/*
  Request handler of a serial-line server: diagnostic counter queries,
  clearing of counters and overrun flag, write-multiple and mask write.
  Assumes: a frame layer delivers decoded PDU bytes one per cycle with
  req_valid_i and a closing req_last_i, CRC and address checking done
  upstream and reported as event pulses; the response is streamed out
  one byte per cycle while resp_ready_i is high.
*/
// Functional notes
// RL1: sub-function 000b returns count of messages seen on the bus
// RL2: sub-function 000c returns count of frames failing CRC
// RL3: sub-function 000d returns count of exception responses sent
// RL4: sub-function 000e returns count of messages processed for us
// RL5: sub-function 000f returns count of addressed messages left unanswered
// RL6: sub-function 0010 returns count of negative-acknowledge exceptions
// RL7: sub-function 0011 returns count of device-busy exceptions
// RL8: sub-function 0012 returns count of messages lost to character overrun
// RL9: counters clear at restart, clear request and reset; query data is zero
// RL10: sub-function 0014 clears overrun count and flag, echoes request
// RL11: function 10 writes 1..0x78 contiguous registers, byte count twice qty; here addresses wrap within the 16-word store
// RL12: write-multiple answers with function, start address and quantity
// RL13: failures answer 0x90 or 0x96 with exception code 01..04
// RL14: mask write result is (cur and amask) or (omask and not amask)
// RL15: mask write echoes request only after the register is updated
// RL16: request addresses are zero based
// RL17: port register reads live lines as input, latch as holding; no read function is served here, 03 and 04 get exception 01
// RL18: one address map for all function codes
// RL19: registers are 16 bits, unused bits read zero
// RL20: diagnostic answers echo function 08 and the sub-function
// RL21: event counters are 16 bits and wrap to zero
`timescale 1ns/1ps
module mb_srv_handler #(
  parameter int MAX_BYTES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic [7:0] req_byte_i,
  input wire logic req_last_i,
  input wire logic ev_bus_msg_i,
  input wire logic ev_crc_err_i,
  input wire logic ev_srv_msg_i,
  input wire logic ev_no_resp_i,
  input wire logic ev_nak_i,
  input wire logic ev_busy_i,
  input wire logic ev_overrun_i,
  input wire logic comm_restart_i,
  input wire logic [7:0] port_pins_i,
  input wire logic resp_ready_i,
  output logic resp_valid_o,
  output logic [7:0] resp_byte_o,
  output logic resp_last_o,
  output logic overrun_flag_o,
  output logic [7:0] port_latch_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_EXEC = 3'b011,
    ST_MASK = 3'b010,
    ST_SEND = 3'b110,
    ST_DRAIN = 3'b111
  } fsm_type;

  typedef struct packed {
    fsm_type fsm;
    logic [7:0] func;
    logic [7:0][7:0] hdr;
    logic [2:0] hcnt;
    logic [7:0] bcnt;
    logic [7:0] dbyte;
    logic dphase;
    logic [15:0] wr_addr;
    logic [15:0] qty;
    logic err;
    logic [7:0] exc;
    logic [7:0][7:0] rsp;
    logic [2:0] rlen;
    logic [2:0] ridx;
    logic ovr_flag;
    logic [7:0] latch;
    logic vld;
    logic [7:0] obyte;
    logic olast;
    logic exc_pulse;
  } state_type;
  state_type st_reg;
  state_type st_next;

  logic [mb_srv_pkg::CNT_NUM-1:0][15:0] cnt;
  logic [mb_srv_pkg::CNT_NUM-1:0] cnt_inc;
  logic [mb_srv_pkg::CNT_NUM-1:0] cnt_clr;
  logic [15:0] hr_rdata;
  logic hr_we;
  logic [mb_srv_pkg::REG_AW-1:0] hr_waddr;
  logic [mb_srv_pkg::REG_AW-1:0] hr_raddr;
  logic [15:0] hr_wdata;
  logic [7:0] pins_s1;
  logic [7:0] pins_s2;
  logic clr_all;
  logic clr_ovr;
  logic [15:0] sub;
  logic [15:0] amask;
  logic [15:0] omask;
  logic [15:0] mask_res;

  ////////////////////////////////////////////////////////////////////////
  // port pins cross from outside through two flops; pins_s2 is not used further
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
    end else begin
      pins_s1 <= port_pins_i;
      pins_s2 <= pins_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RL21: wrapping counter bank
  assign cnt_inc = {ev_overrun_i, ev_busy_i, ev_nak_i, ev_no_resp_i,
                    ev_srv_msg_i, st_reg.exc_pulse, ev_crc_err_i,
                    ev_bus_msg_i};
  // RL9: clear on restart or clear request
  assign cnt_clr = {(clr_all | clr_ovr),
                    {(mb_srv_pkg::CNT_NUM-1){clr_all}}};

  genvar gi;
  generate
    for (gi = 0; gi < mb_srv_pkg::CNT_NUM; gi++) begin : g_cnt
      event_counter #(.WIDTH(16)) u_cnt (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clr_i(cnt_clr[gi]),
        .inc_i(cnt_inc[gi]),
        .count_o(cnt[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // RL18: one holding store serves every function code
  holding_regs #(
    .DEPTH(mb_srv_pkg::REG_COUNT),
    .AW(mb_srv_pkg::REG_AW)
  ) u_regs (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_en_i(hr_we),
    .wr_addr_i(hr_waddr),
    .wr_data_i(hr_wdata),
    .rd_addr_i(hr_raddr),
    .rd_data_o(hr_rdata)
  );

  assign sub = {st_reg.hdr[0], st_reg.hdr[1]};
  assign amask = {st_reg.hdr[2], st_reg.hdr[3]};
  assign omask = {st_reg.hdr[4], st_reg.hdr[5]};
  // RL14: complement of and-mask applied to or-mask
  assign mask_res = (hr_rdata & amask) | (omask & ~amask);
  assign clr_all = comm_restart_i ||
    (st_reg.fsm == ST_EXEC && st_reg.func == mb_srv_pkg::FN_DIAG &&
     sub == mb_srv_pkg::SUB_CLR_CNT);
  // RL10: overrun counter cleared by its own sub-function
  assign clr_ovr = st_reg.fsm == ST_EXEC &&
    st_reg.func == mb_srv_pkg::FN_DIAG && sub == mb_srv_pkg::SUB_CLR_OVR;

  // registers live at zero-based addresses within the store
  always_comb begin
    hr_we = 1'b0;
    hr_waddr = st_reg.wr_addr[mb_srv_pkg::REG_AW-1:0];
    hr_raddr = st_reg.wr_addr[mb_srv_pkg::REG_AW-1:0];
    hr_wdata = '0;
    // RL11: each register word written as its second byte arrives
    if (st_reg.fsm == ST_RECV && req_valid_i && st_reg.dphase &&
        !st_reg.err && st_reg.func == mb_srv_pkg::FN_WR_MULTI &&
        st_reg.hcnt == 3'd5) begin
      hr_we = 1'b1;
      hr_wdata = {st_reg.dbyte, req_byte_i};
    end
    // RL15: register is written before the echo leaves
    if (st_reg.fsm == ST_MASK) begin
      hr_we = 1'b1;
      hr_wdata = mask_res;
    end
    // RL19: the port keeps only its used low byte
    // writes that wrap onto word 0 also reach the port
    if (hr_we &&
        hr_waddr == mb_srv_pkg::ADDR_DIG_PORT[mb_srv_pkg::REG_AW-1:0]) begin
      hr_wdata = hr_wdata & mb_srv_pkg::DIG_USED_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.exc_pulse = 1'b0;
    if (ev_overrun_i) begin
      st_next.ovr_flag = 1'b1;
    end
    case (st_reg.fsm)
      ST_IDLE: begin
        st_next.vld = 1'b0;
        st_next.olast = 1'b0;
        if (req_valid_i) begin
          st_next.func = req_byte_i;
          st_next.hcnt = '0;
          st_next.dphase = 1'b0;
          st_next.err = 1'b0;
          st_next.exc = mb_srv_pkg::EXC_FUNC;
          st_next.fsm = req_last_i ? ST_EXEC : ST_RECV;
        end
      end
      ST_RECV: begin
        if (req_valid_i) begin
          // RL16: addresses are zero based, taken as sent
          if (st_reg.hcnt < 3'd5) begin
            st_next.hdr[st_reg.hcnt] = req_byte_i;
            st_next.hcnt = st_reg.hcnt + 3'd1;
            if (st_reg.hcnt == 3'd1) begin
              st_next.wr_addr = {st_reg.hdr[0], req_byte_i};
            end
            if (st_reg.hcnt == 3'd3) begin
              st_next.qty = {st_reg.hdr[2], req_byte_i};
            end
            // RL11: quantity and byte count checked before data
            if (st_reg.hcnt == 3'd4 &&
                st_reg.func == mb_srv_pkg::FN_WR_MULTI) begin
              st_next.bcnt = req_byte_i;
              if (st_reg.qty < mb_srv_pkg::QTY_MIN ||
                  st_reg.qty > mb_srv_pkg::QTY_MAX ||
                  {8'h00, req_byte_i} != {st_reg.qty[14:0], 1'b0}) begin
                st_next.err = 1'b1;
                st_next.exc = mb_srv_pkg::EXC_VALUE;
              end
            end
          end else if (st_reg.func == mb_srv_pkg::FN_WR_MULTI &&
                       st_reg.hcnt == 3'd5) begin
            // RL11: data bytes beyond the byte count are refused
            st_next.dbyte = req_byte_i;
            st_next.dphase = ~st_reg.dphase;
            if (st_reg.bcnt == 8'h00) begin
              st_next.err = 1'b1;
              st_next.exc = mb_srv_pkg::EXC_VALUE;
            end else begin
              st_next.bcnt = st_reg.bcnt - 8'h01;
            end
            if (st_reg.dphase) begin
              st_next.wr_addr = st_reg.wr_addr + 16'h0001;
            end
          end else begin
            st_next.hdr[st_reg.hcnt] = req_byte_i;
          end
          if (req_last_i) begin
            st_next.fsm = ST_EXEC;
            st_next.wr_addr = {st_reg.hdr[0], st_reg.hdr[1]};
          end
        end
      end
      ST_EXEC: begin
        st_next.ridx = '0;
        st_next.bcnt = '0;
        case (st_reg.func)
          mb_srv_pkg::FN_DIAG: begin
            // RL20: echo function and sub-function
            st_next.rsp[0] = mb_srv_pkg::FN_DIAG;
            st_next.rsp[1] = st_reg.hdr[0];
            st_next.rsp[2] = st_reg.hdr[1];
            st_next.rlen = 3'd4;
            st_next.rsp[3] = st_reg.hdr[2];
            st_next.rsp[4] = st_reg.hdr[3];
            case (sub)
              // RL1: bus message count
              mb_srv_pkg::SUB_BUS_MSG: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_BUS_MSG];
              // RL2: crc error count
              mb_srv_pkg::SUB_BUS_CRC: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_BUS_CRC];
              // RL3: exception count
              mb_srv_pkg::SUB_BUS_EXC: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_BUS_EXC];
              // RL4: processed message count
              mb_srv_pkg::SUB_SRV_MSG: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_SRV_MSG];
              // RL5: unanswered count
              mb_srv_pkg::SUB_SRV_NORSP: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_SRV_NORSP];
              // RL6: nak count
              mb_srv_pkg::SUB_SRV_NAK: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_SRV_NAK];
              // RL7: busy count
              mb_srv_pkg::SUB_SRV_BUSY: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_SRV_BUSY];
              // RL8: overrun count
              mb_srv_pkg::SUB_OVR_CNT: {st_next.rsp[3], st_next.rsp[4]} =
                cnt[mb_srv_pkg::CNT_OVR];
              // RL10: clear flag, echo request; set still wins
              mb_srv_pkg::SUB_CLR_OVR: st_next.ovr_flag = ev_overrun_i;
              mb_srv_pkg::SUB_CLR_CNT: st_next.rlen = 3'd4;
              default: begin
                st_next.err = 1'b1;
                st_next.exc = mb_srv_pkg::EXC_FUNC;
              end
            endcase
            st_next.fsm = ST_SEND;
          end
          mb_srv_pkg::FN_WR_MULTI: begin
            // RL12: function, start address and quantity
            st_next.rsp[0] = mb_srv_pkg::FN_WR_MULTI;
            st_next.rsp[1] = st_reg.hdr[0];
            st_next.rsp[2] = st_reg.hdr[1];
            st_next.rsp[3] = st_reg.qty[15:8];
            st_next.rsp[4] = st_reg.qty[7:0];
            st_next.rlen = 3'd4;
            // RL11: short request or unfilled byte count is refused
            if (st_reg.hcnt != 3'd5 || st_reg.bcnt != 8'h00) begin
              st_next.err = 1'b1;
              st_next.exc = mb_srv_pkg::EXC_VALUE;
            end
            st_next.fsm = ST_SEND;
          end
          mb_srv_pkg::FN_MASK_WR: begin
            // RL15: full echo, sent after ST_MASK writes
            st_next.rsp[0] = mb_srv_pkg::FN_MASK_WR;
            st_next.rsp[7:1] = {8'h00, st_reg.hdr[5:0]};
            st_next.rlen = 3'd6;
            if (st_reg.hcnt != 3'd5 || st_reg.wr_addr >=
                16'(mb_srv_pkg::REG_COUNT)) begin
              st_next.err = 1'b1;
              st_next.exc = mb_srv_pkg::EXC_ADDR;
              st_next.fsm = ST_SEND;
            end else begin
              st_next.fsm = ST_MASK;
            end
          end
          default: begin
            st_next.err = 1'b1;
            st_next.exc = mb_srv_pkg::EXC_FUNC;
            st_next.fsm = ST_SEND;
          end
        endcase
      end
      ST_MASK: begin
        st_next.fsm = ST_SEND;
      end
      ST_SEND: begin
        // RL13: error answer is function or 80 plus one exception byte
        if (st_reg.err) begin
          st_next.rsp[0] = st_reg.func | mb_srv_pkg::ERR_FLAG;
          st_next.rsp[1] = st_reg.exc;
          st_next.rlen = 3'd1;
          st_next.exc_pulse = 1'b1;
          st_next.err = 1'b0;
        end else begin
          st_next.fsm = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!st_reg.vld || resp_ready_i) begin
          if (st_reg.vld && st_reg.olast) begin
            st_next.vld = 1'b0;
            st_next.olast = 1'b0;
            st_next.fsm = ST_IDLE;
          end else begin
            st_next.vld = 1'b1;
            st_next.obyte = st_reg.rsp[st_reg.ridx];
            st_next.olast = st_reg.ridx == st_reg.rlen;
            st_next.ridx = st_reg.ridx + 3'd1;
          end
        end
      end
      default: st_next.fsm = ST_IDLE;
    endcase
    // RL17: output latch follows every store write to word 0
    if (hr_we &&
        hr_waddr == mb_srv_pkg::ADDR_DIG_PORT[mb_srv_pkg::REG_AW-1:0]) begin
      st_next.latch = hr_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign resp_valid_o = st_reg.vld;
  assign resp_byte_o = st_reg.obyte;
  assign resp_last_o = st_reg.olast;
  assign overrun_flag_o = st_reg.ovr_flag;
  // RL17: the latch drives the port; no holding or input read is served
  assign port_latch_o = st_reg.latch;

  chk_clr_counts: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    comm_restart_i |=> cnt[mb_srv_pkg::CNT_BUS_CRC] == 16'h0000) // RL9
    else $error("crc count not cleared by restart");
  chk_ovr_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clr_ovr && !ev_overrun_i |=> !st_reg.ovr_flag) // RL10
    else $error("overrun flag survived its clear");
  chk_mask_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_reg.fsm == ST_MASK |=> !resp_valid_o ##1 !resp_valid_o) // RL15
    else $error("mask echo left before register write");
  chk_diag_echo: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_reg.fsm == ST_EXEC && st_reg.func == mb_srv_pkg::FN_DIAG |=>
    st_reg.rsp[0] == mb_srv_pkg::FN_DIAG && st_reg.rsp[1] ==
    $past(st_reg.hdr[0])) // RL20
    else $error("diagnostic echo wrong");
  chk_err_code: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_reg.exc_pulse |-> st_reg.rsp[0][7] && st_reg.rlen == 3'd1) // RL13
    else $error("exception frame malformed");
  chk_port_bits: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hr_we && hr_waddr == mb_srv_pkg::ADDR_DIG_PORT[mb_srv_pkg::REG_AW-1:0]
    |-> hr_wdata[15:8] == 8'h00) // RL19
    else $error("unused port bits written");
  chk_exc_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_reg.exc_pulse && !clr_all && cnt[mb_srv_pkg::CNT_BUS_EXC] != 16'hffff
    |=> cnt[mb_srv_pkg::CNT_BUS_EXC] ==
    $past(cnt[mb_srv_pkg::CNT_BUS_EXC]) + 16'h0001) // RL3
    else $error("exception count not advanced");
  chk_wm_resp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_reg.fsm == ST_EXEC && st_reg.func == mb_srv_pkg::FN_WR_MULTI |=>
    {st_reg.rsp[3], st_reg.rsp[4]} == $past(st_reg.qty)) // RL12
    else $error("write multiple quantity not echoed");
endmodule

// file: rtl/mb_srv_pkg.sv
/*
  Shared constants for the serial-line server request handler:
  function codes, sub-function codes, exception codes, limits and
  the small register map.
  Assumes: a single 20 MHz system clock and a synchronous reset.
*/
package mb_srv_pkg;
  // function codes
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [7:0] FN_WR_MULTI = 8'h10;
  localparam logic [7:0] FN_MASK_WR = 8'h16;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_INPUT = 8'h04;
  localparam logic [7:0] ERR_FLAG = 8'h80;
  // diagnostic sub-functions
  localparam logic [15:0] SUB_CLR_CNT = 16'h000a;
  localparam logic [15:0] SUB_BUS_MSG = 16'h000b;
  localparam logic [15:0] SUB_BUS_CRC = 16'h000c;
  localparam logic [15:0] SUB_BUS_EXC = 16'h000d;
  localparam logic [15:0] SUB_SRV_MSG = 16'h000e;
  localparam logic [15:0] SUB_SRV_NORSP = 16'h000f;
  localparam logic [15:0] SUB_SRV_NAK = 16'h0010;
  localparam logic [15:0] SUB_SRV_BUSY = 16'h0011;
  localparam logic [15:0] SUB_OVR_CNT = 16'h0012;
  localparam logic [15:0] SUB_CLR_OVR = 16'h0014;
  // exception codes
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;
  // write-multiple quantity limits
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX = 16'h0078;
  // register map: digital port is address 0, the rest are plain words
  localparam int REG_COUNT = 16;
  localparam int REG_AW = 4;
  localparam logic [15:0] ADDR_DIG_PORT = 16'h0000;
  localparam logic [15:0] DIG_USED_MASK = 16'h00ff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // counter index into the counter bank
  localparam int CNT_NUM = 8;
  localparam int CNT_BUS_MSG = 0;
  localparam int CNT_BUS_CRC = 1;
  localparam int CNT_BUS_EXC = 2;
  localparam int CNT_SRV_MSG = 3;
  localparam int CNT_SRV_NORSP = 4;
  localparam int CNT_SRV_NAK = 5;
  localparam int CNT_SRV_BUSY = 6;
  localparam int CNT_OVR = 7;
endpackage

// file: tb/mb_client_model.sv
/*
  Serial-line client model: sends one request pdu a byte per cycle and
  collects the whole response, optionally with a stalling sink.
  Assumes: the handler's byte stream ports and a single clock.
*/
`timescale 1ns/1ps
module mb_client_model (
  input wire logic clk_sys_i,
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_byte_i,
  input wire logic resp_last_i,
  output logic req_valid_o,
  output logic [7:0] req_byte_o,
  output logic req_last_o,
  output logic resp_ready_o
);
  logic [7:0] rx_q[$];
  logic rx_done = 1'b0;
  logic slow = 1'b0;
  initial begin
    req_valid_o = 1'b0;
    req_byte_o = 8'h00;
    req_last_o = 1'b0;
    resp_ready_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // capture sees pre-edge values, so no race with registered outputs
  always @(posedge clk_sys_i) begin
    if (resp_valid_i && resp_ready_o) begin
      rx_q.push_back(resp_byte_i);
      if (resp_last_i) begin
        rx_done = 1'b1;
      end
    end
    resp_ready_o <= slow ? ~resp_ready_o : 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  // whole pdu, one request at a time
  task automatic xfer(input logic [7:0] q[$], input logic s,
                      output logic [7:0] r[$]);
    int n;
    rx_q.delete();
    rx_done = 1'b0;
    slow = s;
    foreach (q[i]) begin
      @(posedge clk_sys_i);
      req_valid_o <= 1'b1;
      req_byte_o <= q[i];
      req_last_o <= (i == q.size() - 1);
    end
    @(posedge clk_sys_i);
    req_valid_o <= 1'b0;
    req_last_o <= 1'b0;
    // a released line must not keep showing the last byte
    req_byte_o <= ~req_byte_o;
    n = 0;
    while (!rx_done && n < 300) begin
      @(posedge clk_sys_i);
      n++;
    end
    @(posedge clk_sys_i);
    r = rx_q;
  endtask
endmodule

// file: tb/serial_server_counters_and_writes_tb.sv
/*
  Self-checking bench for the request handler: counters, clears,
  write-multiple, mask write and exceptions.
  Assumes: mb_client_model drives the request side.
*/
`timescale 1ns/1ps
module serial_server_counters_and_writes_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid, req_last, resp_ready, resp_valid, resp_last, ovr;
  logic [7:0] req_byte, resp_byte, latch;
  logic [6:0] ev = 7'h00;
  logic restart = 1'b0;
  logic [7:0] got[$];
  logic [7:0] wq[$];
  int n_mismatch = 0;
  int tests_run = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  mb_srv_handler u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .req_valid_i(req_valid), .req_byte_i(req_byte),
    .req_last_i(req_last), .ev_bus_msg_i(ev[0]), .ev_crc_err_i(ev[1]),
    .ev_srv_msg_i(ev[2]), .ev_no_resp_i(ev[3]), .ev_nak_i(ev[4]),
    .ev_busy_i(ev[5]), .ev_overrun_i(ev[6]), .comm_restart_i(restart),
    .port_pins_i(8'h5a), .resp_ready_i(resp_ready),
    .resp_valid_o(resp_valid), .resp_byte_o(resp_byte),
    .resp_last_o(resp_last), .overrun_flag_o(ovr),
    .port_latch_o(latch));
  mb_client_model u_cli (.clk_sys_i(clk_sys_i),
    .resp_valid_i(resp_valid), .resp_byte_i(resp_byte),
    .resp_last_i(resp_last), .req_valid_o(req_valid),
    .req_byte_o(req_byte), .req_last_o(req_last),
    .resp_ready_o(resp_ready));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic run(input logic [7:0] q[$], input logic [7:0] e[$],
                     input logic s);
    u_cli.xfer(q, s, got);
    chk(16'(got.size()), 16'(e.size()));
    foreach (e[i]) begin
      if (i < got.size()) begin
        chk({8'h00, got[i]}, {8'h00, e[i]});
      end
    end
  endtask
  task automatic q_cnt(input logic [7:0] sub, input logic [15:0] e,
                       input logic s);
    run({8'h08, 8'h00, sub, 8'h00, 8'h00},
        {8'h08, 8'h00, sub, e[15:8], e[7:0]}, s);
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      ev[k] <= 1'b1;
    end
    @(posedge clk_sys_i);
    ev[k] <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_exc;
    run({8'h08, 8'h00, 8'h05, 8'h00, 8'h00}, {8'h88, 8'h01}, 0);
    run({8'h2b, 8'h00}, {8'hab, 8'h01}, 1);
    run({8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
        {8'h90, 8'h03}, 0);
    run({8'h16, 8'h00, 8'h10, 8'hff, 8'hff, 8'h00, 8'h00},
        {8'h96, 8'h02}, 0);
    $display("test exceptions done");
  endtask
  task automatic t_counters;
    logic [7:0] subs[8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10,
                            8'h11, 8'h12};
    logic [15:0] exp[8] = '{16'h1, 16'h2, 16'h4, 16'h3, 16'h4, 16'h5,
                            16'h6, 16'h7};
    for (int k = 0; k < 7; k++) begin
      pulse(k, k + 1);
    end
    foreach (subs[i]) begin
      q_cnt(subs[i], exp[i], i[0]);
    end
    $display("test counters done");
  endtask
  task automatic t_clear;
    chk({15'h0, ovr}, 16'h1);
    run({8'h08, 8'h00, 8'h14, 8'h00, 8'h00},
        {8'h08, 8'h00, 8'h14, 8'h00, 8'h00}, 1);
    chk({15'h0, ovr}, 16'h0);
    q_cnt(8'h12, 16'h0, 0);
    q_cnt(8'h0b, 16'h1, 0);
    run({8'h08, 8'h00, 8'h0a, 8'h00, 8'h00},
        {8'h08, 8'h00, 8'h0a, 8'h00, 8'h00}, 0);
    q_cnt(8'h0c, 16'h0, 0);
    pulse(1, 3);
    @(posedge clk_sys_i);
    restart <= 1'b1;
    @(posedge clk_sys_i);
    restart <= 1'b0;
    q_cnt(8'h0c, 16'h0, 0);
    $display("test clears done");
  endtask
  task automatic t_writes;
    run({8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'haa, 8'hbb},
        {8'h90, 8'h03}, 0);
    chk({8'h00, latch}, 16'h0000);
    run({8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'hab, 8'h12},
        {8'h10, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
    chk({8'h00, latch}, 16'h0012);
    run({8'h16, 8'h00, 8'h00, 8'h00, 8'hf2, 8'h00, 8'h25},
        {8'h16, 8'h00, 8'h00, 8'h00, 8'hf2, 8'h00, 8'h25}, 1);
    chk({8'h00, latch}, {8'h00, (8'h12 & 8'hf2) | (8'h25 & ~8'hf2)});
    wq = {8'h10, 8'h00, 8'h00, 8'h00, 8'h78, 8'hf0};
    for (int i = 0; i < 240; i++) begin
      wq.push_back(i[7:0]);
    end
    run(wq, {8'h10, 8'h00, 8'h00, 8'h00, 8'h78}, 1);
    // register 0x70 lands last on address 0 after wrapping in 16 words
    chk({8'h00, latch}, 16'h00e1);
    $display("test writes done");
  endtask
  task automatic t_wrap;
    pulse(5, 65537);
    q_cnt(8'h11, 16'h0001, 0);
    $display("test wrap done");
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_exc();
    t_counters();
    t_clear();
    t_writes();
    t_wrap();
    print_verdict();
  end
  // the wrap test alone needs some 66000 cycles; allow 90000 in all
  initial begin
    #4500000;
    n_mismatch++;
    print_verdict();
  end
endmodule
